//--- core/pm_csr_pkg.sv
package pm_csr_pkg;

  // Wishbone address width (byte address bits)
  localparam int ADDR_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] PM_WORD_INDEX = 6'h04;  // Power management control/status
  localparam logic [5:0] DATA_INDEX  = 6'h07;  // Optional data byte
  localparam logic [5:0] IRQ_STAT_INDEX = 6'h08;  // Sticky event status, write one to clear
  localparam logic [5:0] IRQ_MASK_INDEX = 6'h09;  // Interrupt mask, same layout
  localparam logic [5:0] CAP_INDEX   = 6'h0A;  // Capability readback

  // Control/status field positions
  localparam int WAKE_FLAG_BIT  = 15;  // Wake event flag
  localparam int SCALE_LSB      = 13;  // Scaling factor field, two bits
  localparam int SELECT_LSB     = 9;   // Data selector field, four bits
  localparam int WAKE_ALLOW_BIT = 8;   // Wake assertion allow
  localparam int STATE_LSB      = 0;   // Power state field, two bits

  // Capability field positions
  localparam int CAP_COLD_BIT = 15;  // Wake from cold supported
  localparam int CAP_D2_BIT   = 10;  // D2 supported
  localparam int CAP_D1_BIT   = 9;   // D1 supported

  // Event bits of the interrupt status and mask registers
  localparam int EV_WAKE_BIT  = 0;  // Wake event seen
  localparam int EV_STATE_BIT = 1;  // Power state changed
  localparam int EV_W         = 2;  // Number of event bits

  // Reset values
  localparam logic [1:0]      STATE_RST  = 2'h0;
  localparam logic [3:0]      SELECT_RST = 4'h0;
  localparam logic [EV_W-1:0] EV_RST     = 2'h0;
  localparam logic [7:0]      DATA_RST   = 8'h00;

  // Power state encodings
  typedef enum logic [1:0] {
    ST_D0    = 2'h0,
    ST_D1    = 2'h1,
    ST_D2    = 2'h2,
    ST_D3HOT = 2'h3
  } power_state_t;

endpackage

//--- core/pci_pm_control_status.sv
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
// Operation
// - Control/status word at offset four, 16 bits
// - Wake event sets flag regardless of allow
// - Write one clears flag; zero keeps it
// - With cold wake, flag/allow survive reset
// - Without cold wake, reset clears flag/allow
// - Allow bit gates wake output entirely
// - Bits 14:13 read-only scaling factor
// - Bits 12:9 select reported data item
// - No data register: scale/select read zero
// - Bits 1:0 hold power state D0-D3hot
// - Unsupported state write completes, is discarded
// - Strap at power-on sets cold wake support
// - Data byte returns selected item, reads zero when absent
module pci_pm_control_status
  import pm_csr_pkg::*;
#(
  parameter bit DATA_PRESENT = 1'b1,  // Optional data register built
  parameter bit D1_SUPPORT   = 1'b1,  // D1 accepted
  parameter bit D2_SUPPORT   = 1'b1   // D2 accepted
) (
  input  wire logic              clk_i,                  // System clock, 10 MHz
  input  wire logic              rst_i,                  // Sync reset, active high
  input  wire logic              aux_rst_i,              // Power-on reset, clears sticky bits
  input  wire logic              fourth_port_led_strap_i, // Strap, sampled in power-on reset
  input  wire logic              wake_event_i,           // Wake event pulse
  input  wire logic [7:0]        data_value_i,           // Value of the selected item
  input  wire logic [1:0]        data_scale_i,           // Scale of the selected item
  input  wire logic              wb_cyc_i,               // Wishbone cycle
  input  wire logic              wb_stb_i,               // Wishbone strobe
  input  wire logic              wb_we_i,                // Wishbone write enable
  input  wire logic [ADDR_W-1:0] wb_adr_i,               // Wishbone byte address
  input  wire logic [3:0]        wb_sel_i,               // Wishbone byte selects
  input  wire logic [31:0]       wb_dat_i,               // Wishbone write data
  output logic      [31:0]       wb_dat_o,               // Wishbone read data
  output logic                   wb_ack_o,               // Wishbone acknowledge
  output logic      [3:0]        data_select_o,          // Item selector to data source
  output logic      [1:0]        power_state_o,          // Current power state
  output logic                   wake_n_o,               // Wake request, active low
  output logic                   irq_o                   // Level interrupt
);

  // Stored state
  logic              cold_wake_support_r;    // Strap capture
  logic              wake_event_flag_r;      // Sticky wake flag
  logic              wake_assert_allow_r;    // Wake output allowed
  logic [3:0]        select_r;               // Data selector
  logic [1:0]        power_state_field_r;    // Power state
  logic [EV_W-1:0]   ev_stat_r;              // Interrupt status
  logic [EV_W-1:0]   ev_mask_r;              // Interrupt mask
  logic              ack_r;                  // Bus acknowledge
  logic [31:0]       dat_r;                  // Bus read data
  logic              wake_event_flag_nxt;    // Next flag
  logic [EV_W-1:0]   ev_stat_nxt;            // Next status

  // Bus decode
  wire               req       = wb_cyc_i & wb_stb_i;
  wire               take      = req & ~ack_r;            // Request seen, answer next edge
  wire               wr_fire   = req & wb_we_i & ack_r;   // Write lands on the ack edge
  wire [5:0]         word_idx  = wb_adr_i[ADDR_W-1:2];
  wire               hit_pm    = (word_idx == PM_WORD_INDEX);
  wire               hit_data  = (word_idx == DATA_INDEX);
  wire               hit_stat  = (word_idx == IRQ_STAT_INDEX);
  wire               hit_mask  = (word_idx == IRQ_MASK_INDEX);
  wire               hit_cap   = (word_idx == CAP_INDEX);

  // Requested state and whether this part accepts it
  // Only D1 and D2 are optional; D0 and D3hot always pass
  wire [1:0]         st_req    = wb_dat_i[STATE_LSB +: 2];
  wire               st_ok     = (st_req == ST_D0) | (st_req == ST_D3HOT) |
                                 ((st_req == ST_D1) & D1_SUPPORT) |
                                 ((st_req == ST_D2) & D2_SUPPORT);
  // reject whole write
  // Needs the low byte enabled; an upper-byte-only write carries no state
  wire               st_reject = wb_sel_i[0] & ~st_ok;
  wire               pm_wr     = wr_fire & hit_pm & ~st_reject;
  wire               pm_hi_wr  = pm_wr & wb_sel_i[1];  // Flag, select, allow byte
  wire               pm_lo_wr  = pm_wr & wb_sel_i[0];  // State byte
  wire               flag_w1c  = pm_hi_wr & wb_dat_i[WAKE_FLAG_BIT];
  // Rewriting the same state raises no event, so polling software stays quiet
  wire               state_chg = pm_lo_wr & (st_req != power_state_field_r);
  wire [EV_W-1:0]    ev_set    = {state_chg, wake_event_i};
  wire [EV_W-1:0]    ev_clr    = (wr_fire & hit_stat & wb_sel_i[0]) ?
                                 wb_dat_i[EV_W-1:0] : EV_RST;

  // Fields as read back; zeroes scale and select when absent
  // scale is read-only
  wire [1:0]         scaling_factor_field = DATA_PRESENT ? data_scale_i : 2'h0;
  wire [3:0]         select_view = DATA_PRESENT ? select_r : SELECT_RST;
  wire [15:0]        pm_word;
  // reserved bits 7:2 always read zero, writes to them are dropped
  assign pm_word = {wake_event_flag_r, scaling_factor_field, select_view,
                    wake_assert_allow_r, 6'h00, power_state_field_r};
  wire [7:0]         data_view = DATA_PRESENT ? data_value_i : DATA_RST;
  wire [15:0]        cap_word  = {cold_wake_support_r, 4'h0, D2_SUPPORT, D1_SUPPORT, 9'h000};

  // Read multiplexer; unmapped words answer with zero
  wire [31:0]        rd_data =
    hit_pm   ? {16'h0000, pm_word} :
    hit_data ? {24'h00_0000, data_view} :
    hit_stat ? {30'h0000_0000, ev_stat_r} :
    hit_mask ? {30'h0000_0000, ev_mask_r} :
    hit_cap  ? {16'h0000, cap_word} : 32'h0000_0000;

  // Wake flag next value; a new event beats a clear in the same cycle
  // set regardless of allow
  always_comb begin
    wake_event_flag_nxt = wake_event_i | (wake_event_flag_r & ~flag_w1c);
  end

  // Interrupt status next value, set wins over clear
  always_comb begin
    ev_stat_nxt = ev_set | (ev_stat_r & ~ev_clr);
  end

  // Bus answer one cycle after the request; data registered with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= take;
      dat_r <= take ? rd_data : dat_r;
    end
  end

  // strap followed while power-on reset is held, frozen at release
  always_ff @(posedge clk_i) begin
    if (aux_rst_i) begin
      cold_wake_support_r <= fourth_port_led_strap_i;
    end
  end

  // Sticky wake bits: only power-on reset clears them when cold wake exists
  always_ff @(posedge clk_i) begin
    if (aux_rst_i) begin
      wake_event_flag_r   <= 1'b0;
      wake_assert_allow_r <= 1'b0;
    end else if (rst_i && !cold_wake_support_r) begin
      wake_event_flag_r   <= 1'b0;
      wake_assert_allow_r <= 1'b0;
    end else begin
      wake_event_flag_r   <= wake_event_flag_nxt;
      wake_assert_allow_r <= pm_hi_wr ? wb_dat_i[WAKE_ALLOW_BIT] : wake_assert_allow_r;
    end
  end

  // Selector and power state, ordinary reset
  always_ff @(posedge clk_i) begin
    if (rst_i || aux_rst_i) begin
      select_r            <= SELECT_RST;
      power_state_field_r <= STATE_RST;
    end else begin
      select_r            <= pm_hi_wr ? wb_dat_i[SELECT_LSB +: 4] : select_r;
      power_state_field_r <= pm_lo_wr ? st_req : power_state_field_r;
    end
  end

  // Interrupt status and mask
  always_ff @(posedge clk_i) begin
    if (rst_i || aux_rst_i) begin
      ev_stat_r <= EV_RST;
      ev_mask_r <= EV_RST;
    end else begin
      ev_stat_r <= ev_stat_nxt;
      ev_mask_r <= (wr_fire && hit_mask && wb_sel_i[0]) ? wb_dat_i[EV_W-1:0] : ev_mask_r;
    end
  end

  // Outputs; wake output is a function of two flops only, no glitch source
  assign wb_ack_o      = ack_r;
  assign wb_dat_o      = dat_r;
  assign data_select_o = select_view;
  assign power_state_o = power_state_field_r;
  assign wake_n_o      = ~(wake_event_flag_r & wake_assert_allow_r);
  assign irq_o         = |(ev_stat_r & ev_mask_r);

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || aux_rst_i);

  // Bus request and its single-cycle answer
  sequence bus_take_s;
    take;
  endsequence
  sequence bus_answer_s;
    ack_r ##1 !ack_r;
  endsequence

  a_bus_ack_timing: assert property (bus_take_s |=> bus_answer_s)
    else $error("ack not one cycle after request");

  a_pm_read_word: assert property (take && hit_pm |=> wb_dat_o[15:0] == $past(pm_word))
    else $error("control word read mismatch");

  a_flag_sets_event: assert property (wake_event_i |=> wake_event_flag_r)
    else $error("wake flag not set by event");

  a_flag_clear_one: assert property (flag_w1c && !wake_event_i |=> !wake_event_flag_r)
    else $error("wake flag not cleared by one");

  a_flag_keep_zero: assert property (
    pm_hi_wr && !wb_dat_i[WAKE_FLAG_BIT] && wake_event_flag_r |=> wake_event_flag_r)
    else $error("wake flag lost on zero write");

  a_sticky_over_reset: assert property (@(posedge clk_i) disable iff (aux_rst_i)
    rst_i && cold_wake_support_r |=> wake_assert_allow_r == $past(wake_assert_allow_r))
    else $error("sticky allow changed by reset");

  a_plain_reset_clear: assert property (@(posedge clk_i) disable iff (aux_rst_i)
    rst_i && !cold_wake_support_r |=> !wake_event_flag_r && !wake_assert_allow_r)
    else $error("wake bits not cleared by reset");

  a_wake_gated_allow: assert property (!wake_assert_allow_r |-> wake_n_o)
    else $error("wake driven while not allowed");

  a_wake_follows_pair: assert property (
    wake_event_flag_r && wake_assert_allow_r && !pm_hi_wr |=> !wake_n_o)
    else $error("wake not held while flag and allow set");

  a_scale_read_only: assert property (take && hit_pm |=>
    wb_dat_o[SCALE_LSB +: 2] == (DATA_PRESENT ? $past(data_scale_i) : 2'h0))
    else $error("scale field wrong on read");

  a_select_written: assert property (pm_hi_wr |=>
    data_select_o == (DATA_PRESENT ? $past(wb_dat_i[SELECT_LSB +: 4]) : 4'h0))
    else $error("selector not taken");

  a_absent_reads_zero: assert property (take && hit_pm && !DATA_PRESENT |=>
    wb_dat_o[14:9] == 6'h00)
    else $error("scale or select nonzero without data");

  a_state_written: assert property (pm_lo_wr |=> power_state_o == $past(st_req))
    else $error("power state not stored");

  a_state_reject: assert property (wr_fire && hit_pm && st_reject |=>
    $stable(power_state_o) && $stable(wake_assert_allow_r) && $stable(select_r))
    else $error("unsupported state write not discarded");

  a_strap_capture: assert property (@(posedge clk_i)
    $fell(aux_rst_i) |-> cold_wake_support_r == $past(fourth_port_led_strap_i))
    else $error("strap not captured at release");

  a_data_read: assert property (take && hit_data |=>
    wb_dat_o[7:0] == (DATA_PRESENT ? $past(data_value_i) : 8'h00))
    else $error("data byte read mismatch");

  a_irq_level: assert property (ev_stat_r[EV_WAKE_BIT] && ev_mask_r[EV_WAKE_BIT] |-> irq_o)
    else $error("interrupt not raised");

  // Every acknowledge follows a taken request
  a_ack_needs_take: assert property (ack_r |-> $past(take))
    else $error("ack without request");

  // Acknowledge is a single-cycle pulse
  a_ack_single: assert property (ack_r |=> !ack_r)
    else $error("ack longer than one cycle");

  a_wake_idle_high: assert property (!wake_event_flag_r |-> wake_n_o)
    else $error("wake driven without flag");

  a_wake_low_pair: assert property (wake_event_flag_r && wake_assert_allow_r |-> !wake_n_o)
    else $error("wake not driven with flag and allow");

  // Wake event also lands in the interrupt status
  a_stat_wake_set: assert property (wake_event_i |=> ev_stat_r[EV_WAKE_BIT])
    else $error("wake status not set");

  // A real state change raises its event
  a_stat_state_set: assert property (state_chg |=> ev_stat_r[EV_STATE_BIT])
    else $error("state status not set");

  // Wake status clears by one when no new wake event competes
  a_stat_clear_one: assert property (wr_fire && hit_stat && wb_sel_i[0] &&
    wb_dat_i[EV_WAKE_BIT] && !wake_event_i |=> !ev_stat_r[EV_WAKE_BIT])
    else $error("wake status not cleared");

  // Second interrupt source behaves like the first
  a_irq_state_level: assert property (
    ev_stat_r[EV_STATE_BIT] && ev_mask_r[EV_STATE_BIT] |-> irq_o)
    else $error("state interrupt not raised");

  // No unmasked status, no interrupt
  a_irq_quiet: assert property ((ev_stat_r & ev_mask_r) == EV_RST |-> !irq_o)
    else $error("interrupt without unmasked status");

  // Mask takes the written bits
  a_mask_written: assert property (wr_fire && hit_mask && wb_sel_i[0] |=>
    ev_mask_r == $past(wb_dat_i[EV_W-1:0]))
    else $error("mask not written");

  a_allow_written: assert property (pm_hi_wr |=>
    wake_assert_allow_r == $past(wb_dat_i[WAKE_ALLOW_BIT]))
    else $error("allow bit not written");

  a_reserved_zero: assert property (take && hit_pm |=>
    wb_dat_o[7:2] == 6'h00)
    else $error("reserved bits nonzero");

  // Unmapped words answer with zero
  a_unmapped_zero: assert property (take && !(hit_pm || hit_data || hit_stat ||
    hit_mask || hit_cap) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped word nonzero");

  // Read data holds until the next request
  a_dat_holds: assert property (!take |=> $stable(wb_dat_o))
    else $error("read data moved without request");

  a_cap_read: assert property (take && hit_cap |=>
    wb_dat_o[15:0] == {$past(cold_wake_support_r), 4'h0, D2_SUPPORT, D1_SUPPORT, 9'h000})
    else $error("capability read mismatch");

  // flag kept across warm reset when sticky
  a_sticky_flag: assert property (@(posedge clk_i) disable iff (aux_rst_i)
    rst_i && cold_wake_support_r && !wake_event_i |=> wake_event_flag_r == $past(wake_event_flag_r))
    else $error("sticky flag changed by reset");

  // state moves only on a write
  a_state_stays: assert property (!pm_lo_wr |=> $stable(power_state_o))
    else $error("power state moved without write");

  // selector moves only on a write
  a_select_stays: assert property (!pm_hi_wr |=> $stable(data_select_o))
    else $error("selector moved without write");

endmodule

//--- testbench/pci_cfg_host.sv
`timescale 1ns/100ps
// Configuration master standing in for the host, one classic cycle at a time
module pci_cfg_host (
  input  wire logic        clk_i,  // Bus clock
  output logic             cyc_o,  // Cycle
  output logic             stb_o,  // Strobe
  output logic             we_o,   // Write enable
  output logic [7:0]       adr_o,  // Byte address
  output logic [3:0]       sel_o,  // Byte selects
  output logic [31:0]      dat_o,  // Write data
  input  wire logic [31:0] dat_i,  // Read data
  input  wire logic        ack_i   // Acknowledge
);
  int timeouts = 0;  // Waits that ran out
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end
  // Entered just after a rising edge; bounded wait on ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h3;
    // reserved bits 7:2 always written as zero
    dat_o <= (a == 8'h10) ? (d & 32'hFFFF_FF03) : d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    if (n >= 20) timeouts++;
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~dat_o;  // Released data does not keep the old value
    @(posedge clk_i);
  endtask
endmodule

//--- testbench/test_pci_pm_control_status.sv
`timescale 1ns/100ps
module test_pci_pm_control_status;
  import pm_csr_pkg::*;
  logic clk_i = 1'b0;  // Bench clock
  logic rst_i = 1'b1;  // Warm reset
  logic aux_rst_i = 1'b1;  // Power-on reset
  logic strap = 1'b1;  // Cold wake strap, high at first
  logic wake_event_i = 1'b0;  // Wake pulse
  logic cyc, stb, we;  // Bus controls
  logic [7:0] adr;  // Bus address
  logic [3:0] sel;  // Byte selects
  logic [31:0] wdat, rdat;  // Bus data
  logic ack, wake_n_o, irq_o;  // Status outputs
  logic [3:0] data_select_o;  // Item selector
  logic [1:0] power_state_o;  // Power state
  int failures = 0;
  int cmp_count = 0;
  always #50 clk_i = ~clk_i;
  pci_pm_control_status pci_pm_control_status_inst (.clk_i(clk_i), .rst_i(rst_i),
    .aux_rst_i(aux_rst_i), .fourth_port_led_strap_i(strap), .wake_event_i(wake_event_i),
    .data_value_i({4'hA, data_select_o}), .data_scale_i(data_select_o[1:0]),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .data_select_o(data_select_o),
    .power_state_o(power_state_o), .wake_n_o(wake_n_o), .irq_o(irq_o));
  pci_cfg_host pci_cfg_host_inst (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    pci_cfg_host_inst.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
    if (pci_cfg_host_inst.timeouts > 0) end_of_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    pci_cfg_host_inst.xfer(1'b1, a, d, q);
    if (pci_cfg_host_inst.timeouts > 0) end_of_test();
  endtask
  // One-cycle wake pulse; returns when the flag must be visible
  task automatic pulse_wake;
    wake_event_i <= 1'b1;
    @(posedge clk_i);
    wake_event_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic warm_reset(input logic aux, input logic s);
    rst_i <= 1'b1;
    aux_rst_i <= aux;
    strap <= s;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    aux_rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Values straight after power-on, plus an unmapped place
  task automatic reset_values;
    rd(8'h10, 32'h0000_0000);
    rd(8'h28, 32'h0000_8600);
    rd(8'h3C, 32'h0000_0000);
  endtask
  // Every state code, highest first, each a real change
  task automatic power_states;
    logic [1:0] st;
    for (int s = 3; s >= 0; s--) begin
      st = 2'(s);
      wr(8'h10, {30'h0, st} | 32'h0000_00FC);
      rd(8'h10, {30'h0, st});
      chk(32'(power_state_o), {30'h0, st});
    end
    rd(8'h20, 32'h0000_0002);
    wr(8'h20, 32'h0000_0002);
    chk(32'(irq_o), 32'h0000_0000);
  endtask
  // Selector 5; a write to the scale bits must not stick
  task automatic data_select;
    wr(8'h10, 32'h0000_6A00);
    chk(32'(data_select_o), 32'h0000_0005);
    rd(8'h10, 32'h0000_2A00);
    rd(8'h1C, 32'h0000_00A5);
    wr(8'h10, 32'h0000_0000);
  endtask
  // Flag, allow, output and interrupt interplay
  task automatic wake_flow;
    wr(8'h24, 32'h0000_0003);
    pulse_wake();
    chk(32'(wake_n_o), 32'h0000_0001);
    rd(8'h10, 32'h0000_8000);
    wr(8'h10, 32'h0000_0100);
    rd(8'h10, 32'h0000_8100);
    chk(32'(wake_n_o), 32'h0000_0000);
    chk(32'(irq_o), 32'h0000_0001);
    wr(8'h24, 32'h0000_0000);
    chk(32'(irq_o), 32'h0000_0000);
    wr(8'h24, 32'h0000_0001);
    wr(8'h20, 32'h0000_0001);
    chk(32'(irq_o), 32'h0000_0000);
    wr(8'h10, 32'h0000_8100);
    chk(32'(wake_n_o), 32'h0000_0001);
    rd(8'h10, 32'h0000_0100);
  endtask
  // Sticky across warm reset only while cold wake is strapped on
  task automatic sticky;
    pulse_wake();
    warm_reset(1'b0, 1'b1);
    rd(8'h10, 32'h0000_8100);
    warm_reset(1'b1, 1'b0);
    rd(8'h28, 32'h0000_0600);
    wr(8'h10, 32'h0000_0100);
    pulse_wake();
    warm_reset(1'b0, 1'b0);
    rd(8'h10, 32'h0000_0000);
    chk(32'(wake_n_o), 32'h0000_0001);
  endtask
  task automatic end_of_test;
    failures += pci_cfg_host_inst.timeouts;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    aux_rst_i <= 1'b0;
    @(posedge clk_i);
    reset_values();
    power_states();
    data_select();
    wake_flow();
    sticky();
    end_of_test();
  end
endmodule
